// ---- shared/pulse_counter_pkg.sv ----
/*
 Constants for the pulse counter: register byte offsets, field positions,
 reset values, modes and domain timing counts.
 Assumes a 32-bit classic Wishbone bus with byte addressing.
*/
package pulse_counter_pkg;
	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_CNT = 8'h0C;
	localparam logic [7:0] ADR_TOP = 8'h10;
	localparam logic [7:0] ADR_TOPB = 8'h14;
	localparam logic [7:0] ADR_IF = 8'h18;
	localparam logic [7:0] ADR_IFS = 8'h1C;
	localparam logic [7:0] ADR_IFC = 8'h20;
	localparam logic [7:0] ADR_IEN = 8'h24;
	localparam logic [7:0] ADR_SYNCBUSY = 8'h30;

	// ********************************
	// Field positions and reset values
	// ********************************
	localparam int CTRL_DIR_BIT = 2;
	localparam int CTRL_EDGE_BIT = 3;
	localparam int CTRL_FILTER_ENABLE_BIT = 4;
	localparam int CTRL_RST_BIT = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam int FLAG_UNDER = 0;
	localparam int FLAG_OVER = 1;
	localparam int FLAG_DIRCHG = 2;
	localparam int BUSY_CTRL = 0;
	localparam int BUSY_TOP = 1;
	localparam logic [7:0] TOP_RESET = 8'hFF;
	localparam logic [7:0] CNT_RESET = 8'h00;

	// ********************************
	// Timing counts (in counter-domain ticks)
	// ********************************
	localparam logic [2:0] FILTER_ENABLE_SAMPLES = 3'h5;
	localparam logic [1:0] SYNC_TICKS = 2'h2;

	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_OVS = 2'h1,
		MODE_PIN_SINGLE = 2'h2,
		MODE_PIN_QUAD = 2'h3
	} mode_t;
endpackage : pulse_counter_pkg

// ---- design/bit_sync.sv ----
/*
 Two-flip-flop synchroniser for the three external levels.
 Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/10ps
module bit_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Levels
	input wire logic [2:0] din,
	output logic [2:0] dout
);
	logic [2:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 3'h0;
			dout <= 3'h0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : bit_sync

// ---- design/input_filter.sv ----
/*
 Pulse width filter: passes a new level only once it has been seen on
 a fixed number of consecutive sampling ticks; transparent when disabled.
 Assumes din is already synchronised to clk.
*/
`timescale 1ns/10ps
module input_filter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sampling
	input wire logic tick,
	input wire logic enable,
	input wire logic din,
	output logic dout
);
	logic [2:0] stable_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stable_q <= 3'h0;
			dout <= 1'b0;
		end else if (tick) begin
			if (!enable || din == dout) begin
				stable_q <= 3'h0;
				dout <= din;
			end else if (stable_q == pulse_counter_pkg::FILTER_ENABLE_SAMPLES - 3'h1) begin
				stable_q <= 3'h0;
				dout <= din;
			end else begin
				stable_q <= stable_q + 3'h1;
			end
		end
	end
endmodule : input_filter

// ---- design/pulse_counter.sv ----
/*
 Eight-bit up/down pulse counter with reload value, oversampled and
 pin-clocked single-input modes and a quadrature decoder, with a
 Wishbone register slave and one interrupt line.
 Assumes the low-frequency clock and both pins are asynchronous levels
 far slower than clk, which samples them and finds their edges.
*/
`timescale 1ns/10ps

// Functional notes
// - three modes, entered and left via mode field
// - eight-bit up/down counter with top reload
// - oversampled mode samples primary on slow clock
// - single modes count up, down when selected
// - single modes raise only underflow and overflow
// - pin single counts primary rising edges only
// - filter needs five stable samples, oversampled only
// - quadrature samples secondary on both primary edges
// - edge patterns 01/10 and 00/11 both count, in opposite directions
// - primary leading is clockwise; polarity bit inverts
// - direction readable; change raises direction flag
// - domain writes apply after two domain ticks
// - domain reset holds, releases two ticks later
// - slow clock default, primary pin alternative
// - polarity bit picks counted edge when oversampled
// - all flags share one interrupt line
// - down at zero sets underflow, loads top
// - up at top sets overflow, loads zero
// - no event network signals
// - mode codes 0 off, 1 oversampled, 2 pin single, 3 quadrature
module pulse_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Counting clock and pins
	input wire logic lowFreqClock,
	input wire logic primaryInput,
	input wire logic secondaryInput,
	// Interrupt
	output logic counterIrqLine
);
	// ********************************
	// Input sampling and edges
	// ********************************
	logic [2:0] pinsS;
	logic lfS;
	logic s0S;
	logic s1S;
	logic lfPrev_q;
	logic s0Prev_q;
	logic lfTick;
	logic s0Rise;
	logic s0Fall;

	// Only level pins come in; nothing reaches an event network
	bit_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din({lowFreqClock, primaryInput, secondaryInput}),
		.dout(pinsS)
	);
	assign lfS = pinsS[2];
	assign s0S = pinsS[1];
	assign s1S = pinsS[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfPrev_q <= 1'b0;
			s0Prev_q <= 1'b0;
		end else begin
			lfPrev_q <= lfS;
			s0Prev_q <= s0S;
		end
	end

	assign lfTick = lfS & ~lfPrev_q;
	assign s0Rise = s0S & ~s0Prev_q;
	assign s0Fall = ~s0S & s0Prev_q;

	// ********************************
	// Register state
	// ********************************
	logic [5:0] ctrl_q;
	logic [5:0] ctrlDom_q;
	logic [7:0] topBuf_q;
	logic [7:0] top_q;
	logic [7:0] cnt_q;
	logic [2:0] flags_q;
	logic [2:0] flagEn_q;
	logic quadDir_q;
	logic [1:0] relCnt_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic access;
	logic wrEn;
	logic [1:0] wrChan;
	logic [1:0] applyChan;
	logic busy_q [2];
	logic [1:0] syncCnt_q [2];
	logic pinSrc;
	logic domainTick;
	logic held;
	pulse_counter_pkg::mode_t mode;

	// ********************************
	// Wishbone slave
	// ********************************
	// Ack one cycle after the request; the write lands on the ack edge
	assign access = cyc_i & stb_i & ack_q;
	assign wrEn = access & we_i & sel_i[0];
	assign wrChan[pulse_counter_pkg::BUSY_CTRL] = wrEn & (adr_i == pulse_counter_pkg::ADR_CTRL);
	assign wrChan[pulse_counter_pkg::BUSY_TOP] = wrEn & (adr_i == pulse_counter_pkg::ADR_TOPB);
	assign ack_o = ack_q;
	assign dat_o = dat_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= cyc_i & stb_i & ~ack_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_q <= 32'h0;
		end else if (cyc_i & stb_i & ~ack_q & ~we_i) begin
			case (adr_i)
				pulse_counter_pkg::ADR_CTRL: dat_q <= {26'h0, ctrl_q};
				pulse_counter_pkg::ADR_STATUS: dat_q <= {31'h0, quadDir_q};
				pulse_counter_pkg::ADR_CNT: dat_q <= {24'h0, cnt_q};
				pulse_counter_pkg::ADR_TOP: dat_q <= {24'h0, top_q};
				pulse_counter_pkg::ADR_TOPB: dat_q <= {24'h0, topBuf_q};
				pulse_counter_pkg::ADR_IF: dat_q <= {29'h0, flags_q};
				pulse_counter_pkg::ADR_IEN: dat_q <= {29'h0, flagEn_q};
				pulse_counter_pkg::ADR_SYNCBUSY: dat_q <= {30'h0, busy_q[1], busy_q[0]};
				default: dat_q <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= pulse_counter_pkg::CTRL_RESET;
			topBuf_q <= pulse_counter_pkg::TOP_RESET;
			flagEn_q <= 3'h0;
		end else begin
			if (wrChan[pulse_counter_pkg::BUSY_CTRL]) begin
				ctrl_q <= dat_i[5:0];
			end
			if (wrChan[pulse_counter_pkg::BUSY_TOP]) begin
				topBuf_q <= dat_i[7:0];
			end
			if (wrEn && adr_i == pulse_counter_pkg::ADR_IEN) begin
				flagEn_q <= dat_i[2:0];
			end
		end
	end

	// ********************************
	// Counter domain clocking and write sync
	// ********************************
	// The domain ticks on the pin in the pin modes, else on the slow clock
	assign pinSrc = ctrl_q[1];
	assign domainTick = pinSrc ? s0Rise : lfTick;

	// A write may not reach the domain before its second tick; a tick-stalled pin keeps it busy
	for (genvar i = 0; i < 2; i++) begin : g_sync
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				busy_q[i] <= 1'b0;
				syncCnt_q[i] <= 2'h0;
			end else if (wrChan[i]) begin
				busy_q[i] <= 1'b1;
				syncCnt_q[i] <= 2'h0;
			end else if (busy_q[i] && domainTick) begin
				busy_q[i] <= (syncCnt_q[i] != pulse_counter_pkg::SYNC_TICKS - 2'h1);
				syncCnt_q[i] <= syncCnt_q[i] + 2'h1;
			end
		end
		assign applyChan[i] = busy_q[i] & domainTick & ~wrChan[i]
			& (syncCnt_q[i] == pulse_counter_pkg::SYNC_TICKS - 2'h1);
	end

	// Domain control keeps its last value across a domain reset so that
	// a mode written while reset is held still arrives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlDom_q <= pulse_counter_pkg::CTRL_RESET;
		end else if (applyChan[pulse_counter_pkg::BUSY_CTRL]) begin
			ctrlDom_q <= ctrl_q;
		end
	end
	assign mode = pulse_counter_pkg::mode_t'(ctrlDom_q[1:0]);

	// Held at once by the bit; released on the second domain tick after it clears
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			relCnt_q <= pulse_counter_pkg::SYNC_TICKS;
		end else if (ctrl_q[pulse_counter_pkg::CTRL_RST_BIT]) begin
			relCnt_q <= 2'h0;
		end else if (domainTick && relCnt_q != pulse_counter_pkg::SYNC_TICKS) begin
			relCnt_q <= relCnt_q + 2'h1;
		end
	end
	assign held = ctrl_q[pulse_counter_pkg::CTRL_RST_BIT] | (relCnt_q != pulse_counter_pkg::SYNC_TICKS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			top_q <= pulse_counter_pkg::TOP_RESET;
		end else if (held) begin
			top_q <= pulse_counter_pkg::TOP_RESET;
		end else if (applyChan[pulse_counter_pkg::BUSY_TOP]) begin
			top_q <= topBuf_q;
		end
	end

	// ********************************
	// Oversampled input path
	// ********************************
	logic filtLevel;
	logic ovsPrev_q;
	logic ovsEdge;

	input_filter u_filter_enable (
		.clk(clk),
		.rst_n(rst_n),
		.tick(lfTick),
		.enable(ctrlDom_q[pulse_counter_pkg::CTRL_FILTER_ENABLE_BIT] && mode == pulse_counter_pkg::MODE_OVS),
		.din(s0S),
		.dout(filtLevel)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovsPrev_q <= 1'b0;
		end else if (lfTick) begin
			ovsPrev_q <= filtLevel;
		end
	end
	assign ovsEdge = lfTick & (ctrlDom_q[pulse_counter_pkg::CTRL_EDGE_BIT]
		? (ovsPrev_q & ~filtLevel) : (~ovsPrev_q & filtLevel));

	// ********************************
	// Quadrature decode
	// ********************************
	logic patHi;
	logic patLo;
	logic quadEn;
	logic newDir;

	// Secondary level at each primary edge gives the phase relation
	assign patHi = (s0Rise & s1S) | (s0Fall & ~s1S);
	assign patLo = (s0Rise & ~s1S) | (s0Fall & s1S);
	assign quadEn = patHi ^ patLo;
	assign newDir = (patHi & ~patLo) ^ ctrlDom_q[pulse_counter_pkg::CTRL_EDGE_BIT];

	// ********************************
	// Counting
	// ********************************
	logic stepEn;
	logic stepDown;
	logic dirChg;
	logic underEv;
	logic overEv;

	always_comb begin
		stepEn = 1'b0;
		stepDown = ctrlDom_q[pulse_counter_pkg::CTRL_DIR_BIT];
		dirChg = 1'b0;
		case (mode)
			pulse_counter_pkg::MODE_OVS: stepEn = ovsEdge;
			pulse_counter_pkg::MODE_PIN_SINGLE: stepEn = s0Rise;
			pulse_counter_pkg::MODE_PIN_QUAD: begin
				stepEn = quadEn;
				stepDown = newDir;
				dirChg = quadEn & (newDir != quadDir_q);
			end
			default: stepEn = 1'b0;
		endcase
		if (held) begin
			stepEn = 1'b0;
			dirChg = 1'b0;
		end
	end

	assign underEv = stepEn & stepDown & (cnt_q == 8'h00);
	assign overEv = stepEn & ~stepDown & (cnt_q == top_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= pulse_counter_pkg::CNT_RESET;
		end else if (held) begin
			cnt_q <= pulse_counter_pkg::CNT_RESET;
		end else if (underEv) begin
			cnt_q <= top_q;
		end else if (overEv) begin
			cnt_q <= 8'h00;
		end else if (stepEn) begin
			cnt_q <= stepDown ? cnt_q - 8'h01 : cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quadDir_q <= 1'b0;
		end else if (held) begin
			quadDir_q <= 1'b0;
		end else if (mode == pulse_counter_pkg::MODE_PIN_QUAD && quadEn) begin
			quadDir_q <= newDir;
		end
	end

	// ********************************
	// Flags and interrupt line
	// ********************************
	logic [2:0] evSet;
	logic [2:0] swSet;
	logic [2:0] swClr;

	assign evSet = {dirChg, overEv, underEv};
	assign swSet = (wrEn && adr_i == pulse_counter_pkg::ADR_IFS) ? dat_i[2:0] : 3'h0;
	assign swClr = (wrEn && adr_i == pulse_counter_pkg::ADR_IFC) ? dat_i[2:0] : 3'h0;

	// Hardware set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= 3'h0;
		end else begin
			flags_q <= (flags_q & ~swClr) | swSet | evSet;
		end
	end
	assign counterIrqLine = |(flags_q & flagEn_q);

	// ********************************
	// Checks
	// ********************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_under_reload: assert property (underEv |=> cnt_q == $past(top_q)
		&& flags_q[pulse_counter_pkg::FLAG_UNDER]) else $error("underflow reload wrong");
	a_over_wrap: assert property (overEv |=> cnt_q == 8'h00
		&& flags_q[pulse_counter_pkg::FLAG_OVER]) else $error("overflow wrap wrong");
	a_single_nodir: assert property (mode != pulse_counter_pkg::MODE_PIN_QUAD |-> !dirChg)
		else $error("direction flag in single mode");
	a_off_holds: assert property (mode == pulse_counter_pkg::MODE_OFF && !held
		|=> $stable(cnt_q)) else $error("counter moved while off");
	a_domain_reset: assert property (ctrl_q[pulse_counter_pkg::CTRL_RST_BIT]
		|=> cnt_q == 8'h00 && top_q == pulse_counter_pkg::TOP_RESET) else $error("domain not reset");
	a_quad_dir: assert property (mode == pulse_counter_pkg::MODE_PIN_QUAD && !held && patLo
		|=> quadDir_q == ctrlDom_q[pulse_counter_pkg::CTRL_EDGE_BIT]) else $error("quad dir wrong");
	a_top_sync: assert property (wrChan[pulse_counter_pkg::BUSY_TOP] && !held
		|=> busy_q[pulse_counter_pkg::BUSY_TOP] && $stable(top_q)) else $error("top applied early");
	a_irq_line: assert property (flags_q[pulse_counter_pkg::FLAG_DIRCHG]
		&& flagEn_q[pulse_counter_pkg::FLAG_DIRCHG] |-> counterIrqLine) else $error("irq missing");
	a_quad_invalid: assert property (mode == pulse_counter_pkg::MODE_PIN_QUAD && !quadEn
		|=> $stable(cnt_q) || held) else $error("invalid pattern counted");
endmodule : pulse_counter

// ---- tb/pulse_source_model.sv ----
/*
 Far-side model: a free-running low-frequency clock, a pulse source and a
 two-phase shaft encoder on the counter's input pins.
 Assumes the bench calls its tasks just after a rising edge of clk.
*/
`timescale 1ns/10ps
module pulse_source_model (
	// Clock
	input wire logic clk,
	// Pins
	output logic lowFreqClock,
	output logic primaryInput,
	output logic secondaryInput
);
	logic [1:0] divQ;

	initial begin
		divQ = 2'h0;
		lowFreqClock = 1'h0;
		primaryInput = 1'h0;
		secondaryInput = 1'h0;
	end

	// ****************************************
	// Slow clock runs free, 8 clk periods (400 ns)
	// ****************************************
	always @(posedge clk) begin
		divQ <= divQ + 2'h1;
		if (divQ == 2'h3) begin
			lowFreqClock <= ~lowFreqClock;
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	// Every level stands at least 4 clk, above the 3-clk minimum of the sampler
	task automatic setPin(input bit sec, input logic v, input int n);
		if (sec) begin
			secondaryInput <= v;
		end else begin
			primaryInput <= v;
		end
		repeat (n) @(posedge clk);
	endtask : setPin

	task automatic pinPulse(input int n);
		repeat (n) begin
			setPin(1'h0, 1'h1, 4);
			setPin(1'h0, 1'h0, 4);
		end
	endtask : pinPulse

	// Level held for a number of slow-clock periods
	task automatic ovsLevel(input logic v, input int ticks);
		setPin(1'h0, v, ticks * 8);
	endtask : ovsLevel

	task automatic ovsPulse(input int ticks);
		ovsLevel(1'h1, ticks);
		ovsLevel(1'h0, 8);
	endtask : ovsPulse

	// Clockwise: primary leads secondary by a quarter period
	task automatic quad(input int n, input bit ccw);
		repeat (n) begin
			setPin(ccw, 1'h1, 4);
			setPin(!ccw, 1'h1, 4);
			setPin(ccw, 1'h0, 4);
			setPin(!ccw, 1'h0, 4);
		end
	endtask : quad

	task automatic secToggle(input int n);
		repeat (n) begin
			setPin(1'h1, 1'h1, 4);
			setPin(1'h1, 1'h0, 4);
		end
	endtask : secToggle
endmodule : pulse_source_model

// ---- tb/pulse_counter_tb_top.sv ----
/*
 Self-checking bench for the pulse counter: Wishbone register tasks and
 scenarios per counting mode.
 Assumes the pin model in pulse_source_model and the package constants.
*/
`timescale 1ns/10ps
module pulse_counter_tb_top;
	logic clk, rst_n, cyc, stb, we, ack, lfc, pri, sec, irq;
	logic [7:0] adr, exp, top, flags;
	logic [3:0] sel, be;
	logic [31:0] wdat, rdat, rd;
	int err_count, n_tests;
	logic [7:0] rAdr [0:8] = '{pulse_counter_pkg::ADR_CTRL, pulse_counter_pkg::ADR_STATUS,
		pulse_counter_pkg::ADR_CNT, pulse_counter_pkg::ADR_TOP, pulse_counter_pkg::ADR_TOPB,
		pulse_counter_pkg::ADR_IF, pulse_counter_pkg::ADR_IEN, pulse_counter_pkg::ADR_SYNCBUSY,
		8'h3C};
	logic [31:0] rVal [0:8] = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0};

	pulse_counter u_dut (.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.lowFreqClock(lfc), .primaryInput(pri), .secondaryInput(sec), .counterIrqLine(irq));
	pulse_source_model u_src (.clk(clk), .lowFreqClock(lfc), .primaryInput(pri),
		.secondaryInput(sec));

	// Bus interface clock runs from time zero
	always #25 clk = ~clk;

	// ****************************************
	// Access and check tasks
	// ****************************************
	// Waits for the answer however long it takes; only the watchdog ends a hang
	task automatic wbAccess(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= be;
		do begin
			@(posedge clk);
		end while (ack !== 1'h1);
		rd = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk);
	endtask : wbAccess

	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
		n_tests++;
		if (got !== want) begin
			err_count++;
			$display("MISMATCH t=%0t %s: got %h want %h", $time, what, got, want);
		end
	endtask : chk

	task automatic chkRd(input logic [7:0] a, input logic [31:0] want, input string what);
		repeat (8) @(posedge clk);
		wbAccess(1'h0, a, 32'h0);
		chk(rd, want, what);
	endtask : chkRd

	task automatic chkCnt(input string what);
		chkRd(pulse_counter_pkg::ADR_CNT, {24'h0, exp}, what);
	endtask : chkCnt

	// Expected counter step with reload and wrap flags
	task automatic step(input bit up);
		if (up && exp == top) begin
			exp = 8'h00;
			flags[1] = 1'h1;
		end else if (up) begin
			exp = exp + 8'h01;
		end else if (exp == 8'h00) begin
			exp = top;
			flags[0] = 1'h1;
		end else begin
			exp = exp - 8'h01;
		end
	endtask : step

	// Domain reset around every source change; in the pin modes the task drives four pin pulses itself
	task automatic setMode(input logic [31:0] c);
		wbAccess(1'h1, pulse_counter_pkg::ADR_CTRL, 32'h20);
		chkRd(pulse_counter_pkg::ADR_CNT, 32'h0, "domain reset clears count");
		wbAccess(1'h1, pulse_counter_pkg::ADR_CTRL, c);
		if (c[1]) begin
			u_src.pinPulse(4);
		end else begin
			repeat (48) @(posedge clk);
		end
		wbAccess(1'h1, pulse_counter_pkg::ADR_IFC, 32'h7);
		// The release pulses leave a mode-dependent start count
		repeat (8) @(posedge clk);
		wbAccess(1'h0, pulse_counter_pkg::ADR_CNT, 32'h0);
		exp = rd[7:0];
		flags = 8'h00;
	endtask : setMode

	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		clk = 1'h0;
		rst_n = 1'h0;
		cyc = 1'h0;
		stb = 1'h0;
		we = 1'h0;
		adr = 8'h00;
		sel = 4'h0;
		be = 4'hF;
		wdat = 32'h0;
		err_count = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		foreach (rAdr[i]) chkRd(rAdr[i], rVal[i], "reset value");
		$display("test reset values done");
		be = 4'hE;
		wbAccess(1'h1, pulse_counter_pkg::ADR_IEN, 32'h7);
		be = 4'hF;
		chkRd(pulse_counter_pkg::ADR_IEN, 32'h0, "write without byte 0 ignored");
		$display("test byte enable done");
		top = 8'hFF;
		setMode(32'h01);
		u_src.secToggle(2);
		u_src.ovsLevel(1'h1, 8);
		step(1'h1);
		chkCnt("rise counted");
		u_src.ovsLevel(1'h0, 8);
		chkCnt("fall ignored");
		setMode(32'h09);
		u_src.ovsLevel(1'h1, 8);
		chkCnt("rise ignored");
		u_src.ovsLevel(1'h0, 8);
		step(1'h1);
		chkCnt("fall counted");
		$display("test oversampled edges done");
		setMode(32'h15);
		u_src.ovsPulse(2);
		chkCnt("glitch filtered");
		u_src.ovsPulse(8);
		step(1'h0);
		chkCnt("filtered down count");
		$display("test filter done");
		setMode(32'h01);
		// Counter is idle while the new top settles
		wbAccess(1'h1, pulse_counter_pkg::ADR_TOPB, 32'h02);
		top = 8'h02;
		// Two slow ticks must pass before the buffer reaches the top register
		repeat (16) @(posedge clk);
		chkRd(pulse_counter_pkg::ADR_TOP, 32'h02, "top transferred");
		repeat (3) begin
			u_src.ovsPulse(8);
			step(1'h1);
		end
		chkCnt("overflow wrap");
		wbAccess(1'h1, pulse_counter_pkg::ADR_CTRL, 32'h05);
		repeat (48) @(posedge clk);
		u_src.ovsPulse(8);
		step(1'h0);
		chkCnt("underflow reload");
		chkRd(pulse_counter_pkg::ADR_IF, {24'h0, flags}, "wrap flags only");
		wbAccess(1'h1, pulse_counter_pkg::ADR_IEN, 32'h1);
		chk({31'h0, irq}, 32'h1, "irq raised");
		wbAccess(1'h1, pulse_counter_pkg::ADR_IEN, 32'h4);
		chk({31'h0, irq}, 32'h0, "irq masked");
		wbAccess(1'h1, pulse_counter_pkg::ADR_IFS, 32'h4);
		chk({31'h0, irq}, 32'h1, "irq on set flag");
		wbAccess(1'h1, pulse_counter_pkg::ADR_IFC, 32'h7);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		wbAccess(1'h1, pulse_counter_pkg::ADR_CTRL, 32'h00);
		repeat (48) @(posedge clk);
		u_src.ovsPulse(8);
		chkCnt("disabled holds");
		$display("test wrap and irq done");
		top = 8'hFF;
		setMode(32'h0E);
		wbAccess(1'h1, pulse_counter_pkg::ADR_CTRL, 32'h0E);
		chkRd(pulse_counter_pkg::ADR_SYNCBUSY, 32'h1, "busy until pin ticks");
		u_src.secToggle(2);
		u_src.pinPulse(4);
		u_src.ovsLevel(1'h1, 1);
		repeat (5) step(1'h0);
		chkCnt("pin rise down count");
		u_src.ovsLevel(1'h0, 1);
		chkRd(pulse_counter_pkg::ADR_SYNCBUSY, 32'h0, "sync done");
		$display("test pin single done");
		setMode(32'h03);
		u_src.quad(2, 1'h0);
		repeat (4) step(1'h1);
		chkCnt("clockwise up");
		chkRd(pulse_counter_pkg::ADR_STATUS, 32'h0, "dir clockwise");
		wbAccess(1'h1, pulse_counter_pkg::ADR_IFC, 32'h7);
		flags = 8'h04;
		u_src.quad(1, 1'h1);
		repeat (2) step(1'h0);
		chkCnt("counter-clockwise down");
		chkRd(pulse_counter_pkg::ADR_STATUS, 32'h1, "dir reversed");
		chkRd(pulse_counter_pkg::ADR_IF, {24'h0, flags}, "dir change flag");
		setMode(32'h0B);
		u_src.quad(1, 1'h0);
		repeat (2) step(1'h0);
		chkCnt("inverted clockwise");
		chkRd(pulse_counter_pkg::ADR_STATUS, 32'h1, "inverted dir");
		wbAccess(1'h1, pulse_counter_pkg::ADR_CTRL, 32'h23);
		chkRd(pulse_counter_pkg::ADR_CNT, 32'h0, "domain reset count");
		chkRd(pulse_counter_pkg::ADR_STATUS, 32'h0, "domain reset dir");
		$display("test quadrature and domain reset done");
		rst_n <= 1'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		chkRd(pulse_counter_pkg::ADR_CTRL, 32'h0, "control after mid-run reset");
		chkRd(pulse_counter_pkg::ADR_TOPB, 32'hFF, "top buffer after mid-run reset");
		$display("test mid-run reset done");
		close_out();
	end

	// Whole run needs about 2300 clk
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		close_out();
	end
endmodule : pulse_counter_tb_top
